/* verilog/sfel_pkg.sv */
// What this block does
// - call one level deeper appends the new frame's own pointer after copied outer pointers
// - equal-level call copies only outer display entries, never caller's own frame
// - recursive re-entry behaves as equal-level call, no earlier-iteration pointers
// - level-one entry: first word is old frame base, second is new frame base
// - after entry frame base addresses first pushed word, stack pointer the last less storage bytes
// - dynamic storage lies just below the last pushed display word, down to stack pointer
// - level-two entry fetches second display word from caller's second display word
// - level-three entry holds saved frame base, then caller's two display pointers
// - each level above one adds exactly one more copied display word
// - exit loads stack pointer from frame base, then pops saved frame base
// - outside 64-bit mode, eight 32-bit general registers incl frame base and stack
// - six 16-bit segment registers, 32-bit flags and instruction pointer
// - 64-bit mode: sixteen registers, upper eight only via extension prefix, 64-bit wide
// - 64-bit mode widens flags and instruction pointer to 64 bits
// - entry takes nesting level 0..31 and storage byte count subtracted last
// - level zero: push frame base, copy stack pointer, subtract storage, no copies
// - nonzero level: save, latch, copy level-1 words downward, push latched pointer
package sfel_pkg;

  localparam int LEGACY_W  = 32;
  localparam int WIDE_W    = 64;
  localparam int SEG_W     = 16;
  localparam int SEG_NUM   = 6;
  localparam int GPR_NUM   = 16;
  localparam int LEVEL_W   = 5;
  localparam int STORAGE_W = 16;

  localparam logic [3:0]  SP_IDX        = 4'h4;
  localparam logic [3:0]  FB_IDX        = 4'h5;
  localparam logic [63:0] WORD_BYTES_32 = 64'h4;
  localparam logic [63:0] WORD_BYTES_64 = 64'h8;
  localparam logic [63:0] GPR_RST       = 64'h0;
  localparam logic [63:0] FLAGS_RST     = 64'h0;
  localparam logic [63:0] IP_RST        = 64'h0;
  localparam logic [15:0] SEG_RST       = 16'h0;

  typedef enum logic {
    SFEL_OP_ENTER,
    SFEL_OP_LEAVE
  } sfel_op_t;

  typedef enum logic [2:0] {
    S_IDLE,
    S_PUSH_FB,
    S_RD_DISP,
    S_WR_DISP,
    S_PUSH_FP,
    S_ALLOC,
    S_LV_REL,
    S_LV_POP
  } sfel_state_t;

  function automatic logic [63:0] sfel_wb(input logic m64);
    return m64 ? WORD_BYTES_64 : WORD_BYTES_32;
  endfunction

  function automatic logic [63:0] sfel_trunc(input logic [63:0] v, input logic m64);
    return m64 ? v : {32'h0, v[31:0]};
  endfunction

endpackage

/* verilog/sfel_mem_if.sv */
`timescale 1ns/1ps
interface sfel_mem_if;
  logic        req;
  logic        we;
  logic [63:0] addr;
  logic [63:0] wdata;
  logic        done;
  logic [63:0] rdata;

  modport seq  (output req, output we, output addr, output wdata, input done, input rdata);
  modport port (input req, input we, input addr, input wdata, output done, output rdata);
endinterface

/* verilog/sfel_mem_port.sv */
`timescale 1ns/1ps
module sfel_mem_port (
  input  wire logic  clk_sys,
  input  wire logic  arst_n,
  sfel_mem_if.port   mp,
  output logic       mem_req,
  output logic       mem_we,
  output logic [63:0] mem_addr,
  output logic [63:0] mem_wdata,
  input  wire logic  mem_ack,
  input  wire logic [63:0] mem_rdata
);
  logic        busy_q, busy_d;
  logic        we_q, we_d;
  logic [63:0] addr_q, addr_d;
  logic [63:0] wdata_q, wdata_d;

  // ---------------------------------------------------------------
  // one access in flight; sequencer holds req until done
  // ---------------------------------------------------------------
  always_comb begin
    busy_d  = busy_q;
    we_d    = we_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    if (busy_q && mem_ack) begin
      busy_d = 1'b0;
    end else if (!busy_q && mp.req) begin
      busy_d  = 1'b1;
      we_d    = mp.we;
      addr_d  = mp.addr;
      wdata_d = mp.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_q  <= 1'b0;
      we_q    <= 1'b0;
      addr_q  <= 64'h0;
      wdata_q <= 64'h0;
    end else begin
      busy_q  <= busy_d;
      we_q    <= we_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
    end
  end

  assign mp.done   = busy_q & mem_ack;
  assign mp.rdata  = mem_rdata;
  assign mem_req   = busy_q;
  assign mem_we    = we_q;
  assign mem_addr  = addr_q;
  assign mem_wdata = wdata_q;
endmodule

/* verilog/sfel_gpr_mem.sv */
`timescale 1ns/1ps
module sfel_gpr_mem #(
  parameter int W     = 64,
  parameter int DEPTH = 16
) (
  input  wire logic                     clk_sys,
  input  wire logic                     arst_n,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [W-1:0]             wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic [W-1:0]                  rd_data
);
  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [W-1:0] rd_d;

  always_comb begin
    mem_d = mem_q;
    if (wr_en) begin
      mem_d[wr_idx] = wr_data;
    end
    rd_d = mem_q[rd_idx];
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      rd_data <= '0;
    end else begin
      mem_q   <= mem_d;
      rd_data <= rd_d;
    end
  end
endmodule

/* verilog/sfel_top.sv */
`timescale 1ns/1ps
module sfel_top
  import sfel_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire logic                 mode64,
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire logic                 cmd_leave,
  input  wire logic [STORAGE_W-1:0] cmd_storage,
  input  wire logic [LEVEL_W-1:0]   cmd_level,
  output logic                      cmd_done,
  output logic                      mem_req,
  output logic                      mem_we,
  output logic [63:0]               mem_addr,
  output logic [63:0]               mem_wdata,
  input  wire logic                 mem_ack,
  input  wire logic [63:0]          mem_rdata,
  input  wire logic                 register_extension_prefix,
  input  wire logic                 gpr_wide,
  input  wire logic                 gpr_wr_en,
  input  wire logic [3:0]           gpr_wr_idx,
  input  wire logic [63:0]          gpr_wr_data,
  input  wire logic [3:0]           gpr_rd_idx,
  output logic [63:0]               gpr_rd_data,
  input  wire logic                 seg_wr_en,
  input  wire logic [2:0]           seg_wr_idx,
  input  wire logic [SEG_W-1:0]     seg_wr_data,
  input  wire logic [2:0]           seg_rd_idx,
  output logic [SEG_W-1:0]          seg_rd_data,
  input  wire logic                 flags_wr_en,
  input  wire logic [63:0]          flags_wr_data,
  input  wire logic                 ip_wr_en,
  input  wire logic [63:0]          ip_wr_data,
  output logic [63:0]               frame_base_reg,
  output logic [63:0]               stack_pointer_reg,
  output logic [63:0]               flags_reg,
  output logic [63:0]               instr_pointer_reg
);
  sfel_mem_if mif ();

  sfel_state_t           st_q, st_d;
  sfel_op_t              op_q, op_d;
  logic [63:0]           fb_q, fb_d, sp_q, sp_d, fp_q, fp_d;
  logic [63:0]           tmp_q, tmp_d, rd_q, rd_d;
  logic [LEVEL_W-1:0]    lvl_q, lvl_d, cnt_q, cnt_d;
  logic [STORAGE_W-1:0]  stor_q, stor_d;
  logic                  m64_q, m64_d, done_q, done_d;
  logic [63:0]           wb;
  logic                  idle, gpr_ok, gpr_rd_ok, wide_ok;
  logic [63:0]           gpr_wval;
  logic [63:0]           file_rd;
  logic                  rd_spec_q, rd_zero_q;
  logic [63:0]           rd_spec_val_q;
  logic [SEG_W-1:0]      seg_q [SEG_NUM];
  logic [SEG_W-1:0]      seg_rd_q;
  logic [63:0]           flags_q, ip_q;

  assign wb        = sfel_wb(m64_q);
  assign idle      = (st_q == S_IDLE);
  assign cmd_ready = idle;

  // ---------------------------------------------------------------
  // register environment
  // ---------------------------------------------------------------
  // upper eight reachable only with the prefix in 64-bit mode
  assign wide_ok   = mode64 && register_extension_prefix;
  assign gpr_ok    = gpr_wr_en && idle && (!gpr_wr_idx[3] || wide_ok);
  assign gpr_rd_ok = !gpr_rd_idx[3] || wide_ok;
  // narrow writes zero the upper half so legacy code never sees stale bits
  assign gpr_wval  = (wide_ok && gpr_wide) ? gpr_wr_data : {32'h0, gpr_wr_data[31:0]};

  sfel_gpr_mem #(.W(WIDE_W), .DEPTH(GPR_NUM)) u_gpr (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .wr_en   (gpr_ok && gpr_wr_idx != FB_IDX && gpr_wr_idx != SP_IDX),
    .wr_idx  (gpr_wr_idx),
    .wr_data (gpr_wval),
    .rd_idx  (gpr_rd_idx),
    .rd_data (file_rd)
  );

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_spec_q     <= 1'b0;
      rd_zero_q     <= 1'b0;
      rd_spec_val_q <= GPR_RST;
    end else begin
      rd_spec_q     <= (gpr_rd_idx == FB_IDX) || (gpr_rd_idx == SP_IDX);
      rd_zero_q     <= !gpr_rd_ok;
      rd_spec_val_q <= (gpr_rd_idx == FB_IDX) ? fb_q : sp_q;
    end
  end

  assign gpr_rd_data = rd_zero_q ? 64'h0 : (rd_spec_q ? rd_spec_val_q : file_rd);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < SEG_NUM; i++) begin
        seg_q[i] <= SEG_RST;
      end
      seg_rd_q <= SEG_RST;
      flags_q  <= FLAGS_RST;
      ip_q     <= IP_RST;
    end else begin
      if (seg_wr_en && seg_wr_idx < 3'(SEG_NUM)) begin
        seg_q[seg_wr_idx] <= seg_wr_data;
      end
      seg_rd_q <= (seg_rd_idx < 3'(SEG_NUM)) ? seg_q[seg_rd_idx] : SEG_RST;
      if (flags_wr_en) begin
        flags_q <= sfel_trunc(flags_wr_data, mode64);
      end
      if (ip_wr_en) begin
        ip_q <= sfel_trunc(ip_wr_data, mode64);
      end
    end
  end

  assign seg_rd_data       = seg_rd_q;
  assign flags_reg         = flags_q;
  assign instr_pointer_reg = ip_q;
  assign frame_base_reg    = fb_q;
  assign stack_pointer_reg = sp_q;
  assign cmd_done          = done_q;

  // ---------------------------------------------------------------
  // entry / exit sequencer
  // ---------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    op_d      = op_q;
    fb_d      = fb_q;
    sp_d      = sp_q;
    fp_d      = fp_q;
    tmp_d     = tmp_q;
    rd_d      = rd_q;
    cnt_d     = cnt_q;
    lvl_d     = lvl_q;
    stor_d    = stor_q;
    m64_d     = m64_q;
    done_d    = 1'b0;
    mif.req   = 1'b0;
    mif.we    = 1'b0;
    mif.addr  = 64'h0;
    mif.wdata = 64'h0;
    case (st_q)
      S_IDLE: begin
        if (cmd_valid) begin
          op_d   = cmd_leave ? SFEL_OP_LEAVE : SFEL_OP_ENTER;
          lvl_d  = cmd_level;
          stor_d = cmd_storage;
          m64_d  = mode64;
          st_d   = cmd_leave ? S_LV_REL : S_PUSH_FB;
        end else if (gpr_ok && gpr_wr_idx == FB_IDX) begin
          fb_d = gpr_wval;
        end else if (gpr_ok && gpr_wr_idx == SP_IDX) begin
          sp_d = gpr_wval;
        end
      end
      S_PUSH_FB: begin
        mif.req   = 1'b1;
        mif.we    = 1'b1;
        mif.addr  = sfel_trunc(sp_q - wb, m64_q);
        mif.wdata = fb_q;
        if (mif.done) begin
          sp_d  = mif.addr;
          fp_d  = mif.addr;
          tmp_d = fb_q;
          cnt_d = lvl_q - 5'h1;
          if (lvl_q == 5'h0) begin
            st_d = S_ALLOC;
          end else if (lvl_q == 5'h1) begin
            st_d = S_PUSH_FP;
          end else begin
            st_d = S_RD_DISP;
          end
        end
      end
      S_RD_DISP: begin
        // walk the caller display downward from its saved frame base
        mif.req  = 1'b1;
        mif.addr = sfel_trunc(tmp_q - wb, m64_q);
        if (mif.done) begin
          tmp_d = mif.addr;
          rd_d  = sfel_trunc(mif.rdata, m64_q);
          st_d  = S_WR_DISP;
        end
      end
      S_WR_DISP: begin
        mif.req   = 1'b1;
        mif.we    = 1'b1;
        mif.addr  = sfel_trunc(sp_q - wb, m64_q);
        mif.wdata = rd_q;
        if (mif.done) begin
          sp_d  = mif.addr;
          cnt_d = cnt_q - 5'h1;
          st_d  = (cnt_q == 5'h1) ? S_PUSH_FP : S_RD_DISP;
        end
      end
      S_PUSH_FP: begin
        // the new frame's own pointer goes last, after the outer copies
        mif.req   = 1'b1;
        mif.we    = 1'b1;
        mif.addr  = sfel_trunc(sp_q - wb, m64_q);
        mif.wdata = fp_q;
        if (mif.done) begin
          sp_d = mif.addr;
          st_d = S_ALLOC;
        end
      end
      S_ALLOC: begin
        // dynamic area then sits just below the last pushed display word
        fb_d   = fp_q;
        sp_d   = sfel_trunc(sp_q - {48'h0, stor_q}, m64_q);
        done_d = 1'b1;
        st_d   = S_IDLE;
      end
      S_LV_REL: begin
        sp_d = fb_q;
        st_d = S_LV_POP;
      end
      S_LV_POP: begin
        mif.req  = 1'b1;
        mif.addr = sp_q;
        if (mif.done) begin
          fb_d   = sfel_trunc(mif.rdata, m64_q);
          sp_d   = sfel_trunc(sp_q + wb, m64_q);
          done_d = 1'b1;
          st_d   = S_IDLE;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= S_IDLE;
      op_q   <= SFEL_OP_ENTER;
      fb_q   <= GPR_RST;
      sp_q   <= GPR_RST;
      fp_q   <= GPR_RST;
      tmp_q  <= GPR_RST;
      rd_q   <= GPR_RST;
      cnt_q  <= 5'h0;
      lvl_q  <= 5'h0;
      stor_q <= 16'h0;
      m64_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      op_q   <= op_d;
      fb_q   <= fb_d;
      sp_q   <= sp_d;
      fp_q   <= fp_d;
      tmp_q  <= tmp_d;
      rd_q   <= rd_d;
      cnt_q  <= cnt_d;
      lvl_q  <= lvl_d;
      stor_q <= stor_d;
      m64_q  <= m64_d;
      done_q <= done_d;
    end
  end

  sfel_mem_port u_port (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .mp        (mif),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [63:0] ent_sp_q, ent_fb_q;
  logic [5:0]  wr_cnt_q;
  logic [63:0] words;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ent_sp_q <= 64'h0;
      ent_fb_q <= 64'h0;
      wr_cnt_q <= 6'h0;
    end else if (idle && cmd_valid) begin
      ent_sp_q <= sp_q;
      ent_fb_q <= fb_q;
      wr_cnt_q <= 6'h0;
    end else if (mif.done && mif.we) begin
      wr_cnt_q <= wr_cnt_q + 6'h1;
    end
  end

  assign words = (lvl_q == 5'h0) ? 64'h1 : {59'h0, lvl_q} + 64'h1;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_issue_hold;
    idle && cmd_valid |=> !cmd_ready ##1 !cmd_ready;
  endproperty
  a_issue_hold: assert property (p_issue_hold) else $error("issue not held");

  property p_lvl0_no_copy;
    st_q == S_RD_DISP |-> lvl_q > 5'h1 && op_q == SFEL_OP_ENTER;
  endproperty
  a_lvl0_no_copy: assert property (p_lvl0_no_copy) else $error("display read at level<2");

  property p_entry_regs;
    done_q && op_q == SFEL_OP_ENTER |-> fb_q == sfel_trunc(ent_sp_q - wb, m64_q)
      && sp_q == sfel_trunc(ent_sp_q - wb * words - {48'h0, stor_q}, m64_q);
  endproperty
  a_entry_regs: assert property (p_entry_regs) else $error("frame regs wrong after entry");

  property p_word_count;
    done_q && op_q == SFEL_OP_ENTER |-> {58'h0, wr_cnt_q} == words;
  endproperty
  a_word_count: assert property (p_word_count) else $error("display word count wrong");

  property p_copy_walk;
    st_q == S_RD_DISP && mif.done |=> tmp_q == sfel_trunc($past(tmp_q) - wb, m64_q);
  endproperty
  a_copy_walk: assert property (p_copy_walk) else $error("display read not descending");

  property p_own_ptr;
    st_q == S_PUSH_FP |-> mif.wdata == sfel_trunc(ent_sp_q - wb, m64_q);
  endproperty
  a_own_ptr: assert property (p_own_ptr) else $error("frame pointer push wrong");

  property p_leave;
    st_q == S_LV_POP && mif.done |=> fb_q == sfel_trunc($past(mem_rdata), m64_q)
      && sp_q == sfel_trunc($past(sp_q) + wb, m64_q) && done_q;
  endproperty
  a_leave: assert property (p_leave) else $error("exit restore wrong");

  property p_rex_gate;
    gpr_rd_idx[3] && !wide_ok |=> gpr_rd_data == 64'h0;
  endproperty
  a_rex_gate: assert property (p_rex_gate) else $error("upper register read w/o prefix");

  property p_legacy_width;
    flags_wr_en && !mode64 |=> flags_reg[63:32] == 32'h0;
  endproperty
  a_legacy_width: assert property (p_legacy_width) else $error("flags wide in legacy");

  c_lvl0:  cover property (st_q == S_PUSH_FB ##1 st_q == S_ALLOC);
  c_lvl3:  cover property (done_q && op_q == SFEL_OP_ENTER && lvl_q == 5'h3);
  c_leave: cover property (done_q && op_q == SFEL_OP_LEAVE);
  c_rex:   cover property (gpr_ok && gpr_wr_idx[3]);
endmodule

/* dv/sfel_mem_model.sv */
`timescale 1ns/1ps
module sfel_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [3:0]  lat,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [63:0] mem_addr,
  input  wire logic [63:0] mem_wdata,
  output logic             mem_ack,
  output logic [63:0]      mem_rdata
);
  // ----------------------------------------
  // stack memory, sparse, by byte address
  // ----------------------------------------
  logic [63:0] mem [logic [63:0]];
  int          wr_cnt = 0;
  logic [3:0]  wait_q;

  // unwritten words read back as ~addr, never as a quiet zero
  function automatic logic [63:0] peek(input logic [63:0] a);
    return mem.exists(a) ? mem[a] : ~a;
  endfunction

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack   <= 1'h0;
      wait_q    <= 4'h0;
      mem_rdata <= 64'hFFFF_FFFF_FFFF_FFFF;
    end else if (mem_ack || !mem_req) begin
      mem_ack   <= 1'h0;
      wait_q    <= 4'h0;
      // released data toggles so stale read data cannot pass
      mem_rdata <= ~mem_rdata;
    end else if (wait_q == lat) begin
      mem_ack <= 1'h1;
      if (mem_we) begin
        mem[mem_addr] = mem_wdata;
        wr_cnt++;
      end else begin
        mem_rdata <= peek(mem_addr);
      end
    end else begin
      wait_q    <= wait_q + 4'h1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

/* dv/sfel_top_tb.sv */
`timescale 1ns/1ps
module sfel_top_tb;
  import sfel_pkg::*;
  logic        clk_sys = 1'h0, arst_n = 1'h0, mode64 = 1'h0;
  logic        cmd_valid = 1'h0, cmd_leave = 1'h0, cmd_ready, cmd_done;
  logic [15:0] cmd_storage = 16'h0;
  logic [4:0]  cmd_level = 5'h0;
  logic        mem_req, mem_we, mem_ack;
  logic [63:0] mem_addr, mem_wdata, mem_rdata;
  logic [3:0]  lat = 4'h0, gpr_wr_idx = 4'h0, gpr_rd_idx = 4'h0;
  logic        register_extension_prefix = 1'h0, gpr_wide = 1'h0, gpr_wr_en = 1'h0;
  logic [63:0] gpr_wr_data = 64'h0, gpr_rd_data;
  logic        seg_wr_en = 1'h0, flags_wr_en = 1'h0, ip_wr_en = 1'h0;
  logic [2:0]  seg_wr_idx = 3'h0, seg_rd_idx = 3'h0;
  logic [15:0] seg_wr_data = 16'h0, seg_rd_data;
  logic [63:0] flags_wr_data = 64'h0, ip_wr_data = 64'h0;
  logic [63:0] frame_base_reg, stack_pointer_reg, flags_reg, instr_pointer_reg;
  int          failures = 0, checks = 0, cycles = 0;

  always #5 clk_sys = ~clk_sys;

  sfel_top sfel_top_inst (.clk_sys, .arst_n, .mode64, .cmd_valid, .cmd_ready, .cmd_leave,
    .cmd_storage, .cmd_level, .cmd_done, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata, .register_extension_prefix, .gpr_wide, .gpr_wr_en, .gpr_wr_idx, .gpr_wr_data,
    .gpr_rd_idx, .gpr_rd_data, .seg_wr_en, .seg_wr_idx, .seg_wr_data, .seg_rd_idx,
    .seg_rd_data, .flags_wr_en, .flags_wr_data, .ip_wr_en, .ip_wr_data, .frame_base_reg,
    .stack_pointer_reg, .flags_reg, .instr_pointer_reg);

  sfel_mem_model mem_inst (.clk_sys, .arst_n, .lat, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wr_gpr(input logic [3:0] idx, input logic [63:0] d);
    @(posedge clk_sys);
    gpr_wr_en   <= 1'h1;
    gpr_wr_idx  <= idx;
    gpr_wr_data <= d;
    @(posedge clk_sys);
    gpr_wr_en <= 1'h0;
  endtask

  task automatic rd_gpr(input logic [3:0] idx, output logic [63:0] d);
    @(posedge clk_sys);
    gpr_rd_idx <= idx;
    repeat (2) @(posedge clk_sys);
    #1 d = gpr_rd_data;
  endtask

  // a stray stack pointer write lands while busy; it must be dropped
  task automatic run_cmd(input logic lv, input logic [4:0] lvl, input logic [15:0] st);
    int n;
    @(posedge clk_sys);
    cmd_valid   <= 1'h1;
    cmd_leave   <= lv;
    cmd_level   <= lvl;
    cmd_storage <= st;
    @(posedge clk_sys);
    cmd_valid   <= 1'h0;
    gpr_wr_en   <= 1'h1;
    gpr_wr_idx  <= SP_IDX;
    gpr_wr_data <= 64'hDEAD;
    @(posedge clk_sys);
    gpr_wr_en <= 1'h0;
    #1 chk(cmd_ready, 1'h0);
    for (n = 0; n < 400 && cmd_done !== 1'h1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(cmd_done, 1'h1);
    chk(cmd_ready, 1'h1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic run_enter(input logic m, input logic [4:0] lvl, input logic [15:0] st,
                           input logic [63:0] s, input logic [63:0] f);
    logic [63:0] wb, pv, nw, e, d;
    int          w0;
    wb = m ? 64'h8 : 64'h4;
    pv = m ? 64'hC0DE_0000_0000_5A00 : 64'h5A00;
    nw = (lvl == 5'h0) ? 64'h1 : 64'h1 + lvl;
    // legacy mode wraps at 32 bits, so a large storage count stays in the low half
    e  = s - wb * nw - st;
    if (!m) e[63:32] = 32'h0;
    @(posedge clk_sys);
    mode64 <= m;
    wr_gpr(SP_IDX, s);
    wr_gpr(FB_IDX, f);
    rd_gpr(SP_IDX, d);
    chk(d, s);
    for (int i = 1; i < lvl; i++) mem_inst.mem[f - i * wb] = pv + i;
    w0 = mem_inst.wr_cnt;
    #1 chk(frame_base_reg, f);
    run_cmd(1'h0, lvl, st);
    chk(mem_inst.peek(s - wb), f);
    for (int i = 1; i < lvl; i++) chk(mem_inst.peek(s - (i + 1) * wb), pv + i);
    if (lvl > 0) chk(mem_inst.peek(s - (lvl + 1) * wb), s - wb);
    chk(mem_inst.wr_cnt - w0, nw);
    chk(frame_base_reg, s - wb);
    chk(frame_base_reg + wb, s);
    chk(stack_pointer_reg, e);
    run_cmd(1'h1, 5'h0, 16'h0);
    chk(frame_base_reg, f);
    chk(stack_pointer_reg, s);
  endtask

  task automatic run_regs();
    logic [63:0] d;
    wr_gpr(4'h2, 64'hFFFF_FFFF_1234_5678);
    rd_gpr(4'h2, d);
    chk(d, 64'h1234_5678);
    @(posedge clk_sys);
    mode64 <= 1'h1;
    wr_gpr(4'h9, 64'h0123_4567_89AB_CDEF);
    rd_gpr(4'h9, d);
    chk(d, 64'h0);
    @(posedge clk_sys);
    register_extension_prefix <= 1'h1;
    gpr_wide                  <= 1'h1;
    // the earlier write without the prefix must have left the register untouched
    rd_gpr(4'h9, d);
    chk(d, 64'h0);
    wr_gpr(4'h9, 64'h0123_4567_89AB_CDEF);
    rd_gpr(4'h9, d);
    chk(d, 64'h0123_4567_89AB_CDEF);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      seg_wr_en   <= 1'h1;
      seg_wr_idx  <= i[2:0];
      seg_wr_data <= 16'hA000 + i[15:0];
      seg_rd_idx  <= i[2:0];
      @(posedge clk_sys);
      seg_wr_en <= 1'h0;
      @(posedge clk_sys);
      #1 chk(seg_rd_data, (i < 6) ? 16'hA000 + i[15:0] : 16'h0);
    end
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys);
      mode64        <= m[0];
      flags_wr_en   <= 1'h1;
      ip_wr_en      <= 1'h1;
      flags_wr_data <= 64'hF0F0_0000_0000_0ACE;
      ip_wr_data    <= 64'h8000_0000_0040_1000;
      @(posedge clk_sys);
      flags_wr_en <= 1'h0;
      ip_wr_en    <= 1'h0;
      #1 chk(flags_reg, m ? 64'hF0F0_0000_0000_0ACE : 64'h0ACE);
      chk(instr_pointer_reg, m ? 64'h8000_0000_0040_1000 : 64'h0040_1000);
    end
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  initial begin
    static logic [4:0] lvls [5] = '{5'h0, 5'h1, 5'h2, 5'h3, 5'h1F};
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'h1;
    @(posedge clk_sys);
    #1 chk(cmd_ready, 1'h1);
    chk(stack_pointer_reg, 64'h0);
    chk(frame_base_reg, 64'h0);
    run_regs();
    foreach (lvls[i]) run_enter(1'h0, lvls[i], (i == 4) ? 16'hFFFF : 16'h0C, 64'h8000, 64'h9000);
    @(posedge clk_sys);
    lat <= 4'h3;
    run_enter(1'h1, 5'h2, 16'h0800, 64'h0012_0000_8000, 64'h0012_0001_0000);
    run_enter(1'h0, 5'h3, 16'h0, 64'hF000, 64'hF100);
    tally_and_finish();
  end
endmodule
